// ### hdl/dmr_ctrl_end.sv
`timescale 1ns/1ps
module dmr_ctrl_end #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic  psel,
	input  wire logic  penable,
	input  wire logic  pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic       pready,
	output logic       pslverr,
	// Command link
	dmr_link_if.ctrl   link
);
	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic [21:0] data_img;
	logic [1:0]  config_bits;
	logic        err;
	logic        dll_on;
	logic        in_sr;
	logic        lock_busy;
	logic        refuse;
	logic [21:0] clean_img;

	wire [7:0] offs    = 8'(paddr);
	wire       access  = psel && penable;
	wire       hit_cmd = (offs == dmr_pkg::DMR_REG_CMD);
	wire       hit_dat = (offs == dmr_pkg::DMR_REG_DATA);
	wire       hit_st  = (offs == dmr_pkg::DMR_REG_STATUS);
	wire       hit_cf  = (offs == dmr_pkg::DMR_REG_CONFIG);
	wire       mapped  = hit_cmd || hit_dat || hit_st || hit_cf;
	wire       wr_cmd  = access && pwrite && hit_cmd;
	wire       gear    = config_bits[dmr_pkg::DMR_CF_GEAR];
	wire [2:0] img_sel = data_img[20:18];
	wire       sel_mr0 = (img_sel == dmr_pkg::DMR_SEL_MR0);
	wire       sel_mr1 = (img_sel == dmr_pkg::DMR_SEL_MR1);
	wire       sel_mr2 = (img_sel == dmr_pkg::DMR_SEL_MR2);
	wire       dll_rst_req = sel_mr0 && data_img[8] && dll_on;
	wire       lock_start;
	wire [31:0] status_word = {28'h0000000, in_sr, dll_on, err, lock_busy};
	dmr_pkg::dmr_op_t op;

	assign op      = dmr_pkg::dmr_op_t'(pwdata[2:0]);
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// Mode image with forced-zero fields
	assign clean_img = data_img & ~(dmr_pkg::DMR_RSV_MASK |
		(sel_mr1 ? dmr_pkg::DMR_RXEQ_MASK : 22'h000000) |
		((sel_mr1 && !data_img[0]) ?
			dmr_pkg::DMR_NOM_MASK : 22'h000000) |
		((sel_mr2 && !dll_on) ?
			dmr_pkg::DMR_WRT_MASK : 22'h000000));

	// Refusal of orders that would break the device's conditions
	always_comb begin
		refuse = 1'b0;
		unique case (op)
			dmr_pkg::DMR_OP_NOP: refuse = 1'b0;
			dmr_pkg::DMR_OP_MRS: refuse = in_sr || (sel_mr1 && gear &&
				(data_img[4:3] == dmr_pkg::DMR_AL_M1));
			dmr_pkg::DMR_OP_ACT: refuse = in_sr;
			dmr_pkg::DMR_OP_RD:  refuse = in_sr || lock_busy ||
				!dll_on;
			dmr_pkg::DMR_OP_WR:  refuse = in_sr;
			dmr_pkg::DMR_OP_SRE: refuse = in_sr || lock_busy;
			dmr_pkg::DMR_OP_SRX: refuse = !in_sr;
			default:             refuse = 1'b1;
		endcase
	end

	wire issue = wr_cmd && !refuse;
	assign lock_start = issue && (((op == dmr_pkg::DMR_OP_MRS) &&
		dll_rst_req) || ((op == dmr_pkg::DMR_OP_SRX) && dll_on));

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------

	// Data image, configuration and read data at setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_img    <= '0;
			config_bits <= 2'h0;
			prdata      <= 32'h00000000;
		end else begin
			if (access && pwrite && hit_dat) begin
				data_img <= pwdata[21:0];
			end
			if (access && pwrite && hit_cf) begin
				config_bits <= pwdata[1:0];
			end
			if (psel && !penable) begin
				prdata <= hit_dat ? {10'h000, data_img} :
					hit_st ? status_word :
					hit_cf ? {30'h0, config_bits} : 32'h00000000;
			end
		end
	end

	// Sticky refusal flag; a new refusal beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err <= 1'b0;
		end else if (wr_cmd && refuse) begin
			err <= 1'b1;
		end else if (access && pwrite && hit_st &&
				pwdata[dmr_pkg::DMR_ST_ERR]) begin
			err <= 1'b0;
		end
	end

	// Shadow of loop enable and self-refresh state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dll_on <= 1'b0;
			in_sr  <= 1'b0;
		end else if (issue) begin
			if ((op == dmr_pkg::DMR_OP_MRS) && sel_mr1) begin
				dll_on <= data_img[0];
			end
			if (op == dmr_pkg::DMR_OP_SRE) begin
				in_sr <= 1'b1;
			end else if (op == dmr_pkg::DMR_OP_SRX) begin
				in_sr <= 1'b0;
			end
		end
	end

	// Wait out the lock interval before reads
	dmr_lock_timer #(
		.CYCLES (dmr_pkg::DMR_LOCK_CYCLES)
	) u_lock (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (lock_start),
		.enable  (dll_on && !in_sr),
		.hold_ok (link.cke),
		.busy    (lock_busy),
		.locked  ()
	);

	// ----------------------------------------------------------------
	// Link drive
	// ----------------------------------------------------------------

	// One-cycle command, then idle; clock enable low only in self-refresh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.cs_n <= 1'b1;
			link.cmd  <= dmr_pkg::DMR_CMD_NOP;
			link.cke  <= 1'b1;
			link.odt  <= 1'b0;
			link.bg   <= 2'h0;
			link.ba   <= 2'h0;
			link.a    <= '0;
		end else begin
			link.odt  <= config_bits[dmr_pkg::DMR_CF_ODT] &&
				dll_on;
			link.cs_n <= 1'b1;
			link.cmd  <= dmr_pkg::DMR_CMD_NOP;
			if (issue && (op != dmr_pkg::DMR_OP_NOP) &&
					(op != dmr_pkg::DMR_OP_SRX)) begin
				link.cs_n <= 1'b0;
				link.bg   <= clean_img[21:20];
				link.ba   <= clean_img[19:18];
				link.a    <= clean_img[17:0];
			end
			if (issue) begin
				unique case (op)
					dmr_pkg::DMR_OP_MRS: link.cmd <= dmr_pkg::DMR_CMD_MRS;
					dmr_pkg::DMR_OP_ACT: link.cmd <= dmr_pkg::DMR_CMD_ACT;
					dmr_pkg::DMR_OP_RD:  link.cmd <= dmr_pkg::DMR_CMD_RD;
					dmr_pkg::DMR_OP_WR:  link.cmd <= dmr_pkg::DMR_CMD_WR;
					dmr_pkg::DMR_OP_SRE: link.cmd <= dmr_pkg::DMR_CMD_REF;
					default:             link.cmd <= dmr_pkg::DMR_CMD_NOP;
				endcase
				if (op == dmr_pkg::DMR_OP_SRE) begin
					link.cke <= 1'b0;
				end else if (op == dmr_pkg::DMR_OP_SRX) begin
					link.cke <= 1'b1;
				end
			end
		end
	end
endmodule : dmr_ctrl_end

// ### hdl/dmr_dram_end.sv
// Function
// - Controller writes zero to bits 21, 17.
// - Bit 12 disconnects drivers and termination.
// - Bit 11 enables extra strobe, by-8 only.
// - Bits 10:8 pick nominal termination ohms.
// - Bit 7 enters write leveling mode.
// - Controller keeps receiver equalization at 000.
// - Bits 4:3 pick additive latency.
// - No latency minus one in gear-down.
// - Bits 2:1 pick driver impedance.
// - Bit 0 enables the delay-locked loop.
// - Loop enabled for normal operation.
// - Self-refresh turns loop off, then on.
// - Wait lock time before READ after reset.
// - Clock enable high throughout lock interval.
// - Writes need loop only with write termination; the controller refuses a WRITE only in self-refresh.
// - Loop off keeps termination disabled; the controller drives the termination pin low but never masks park termination.
// - Loop off clears write termination field; the controller masks bits 10:9 only, not bit 11.
// - Write termination applies during writes.
// - Park termination while termination pin low.
// - Hold column commands for additive latency.
// - Total latencies add additive latency.
// - Mode set carries select and fields.
// - Loop reset bit clears itself.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dmr_dram_end #(
	parameter int   MAX_AL = dmr_pkg::DMR_MAX_AL,
	parameter logic IS_X8  = 1'b1
) (
	// Clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// Command link
	dmr_link_if.dev    link,
	// Latency from the first mode register
	input  wire logic [5:0] read_cas_delay,
	// Decoded settings
	output logic       output_disable,
	output logic       extra_termination_strobe,
	output logic [7:0] nominal_termination_ohm,
	output logic       write_leveling_mode,
	output logic [2:0] receiver_equalization,
	output logic [5:0] additive_cmd_delay,
	output logic [7:0] driver_impedance_ohm,
	output logic [6:0] read_total_delay,
	output logic [6:0] write_total_delay,
	// Pin state
	output logic       driver_on,
	output logic [7:0] termination_ohm,
	// Loop state
	output logic       dll_active,
	output logic       dll_locked,
	output logic       dll_reset_bit,
	output logic       self_refresh,
	// Internal column commands
	output logic       int_read,
	output logic       int_write,
	output logic       read_dll_fault,
	output logic       write_dll_fault
);
	localparam logic [5:0] AL_MAX_TAP = 6'(MAX_AL);

	// ----------------------------------------------------------------
	// Lookups
	// ----------------------------------------------------------------

	// Nominal and park code to ohms, zero meaning off
	function automatic logic [7:0] nom_ohm(input logic [2:0] code);
		case (code)
			3'h1:    nom_ohm = 8'h3c;
			3'h2:    nom_ohm = 8'h78;
			3'h3:    nom_ohm = 8'h28;
			3'h4:    nom_ohm = 8'hf0;
			3'h5:    nom_ohm = 8'h30;
			3'h6:    nom_ohm = 8'h50;
			3'h7:    nom_ohm = 8'h22;
			default: nom_ohm = 8'h00;
		endcase
	endfunction : nom_ohm

	// Write termination code to ohms; high-Z and reserved give zero
	function automatic logic [7:0] wr_ohm(input logic [2:0] code);
		case (code)
			3'h1:    wr_ohm = 8'h78;
			3'h2:    wr_ohm = 8'hf0;
			3'h4:    wr_ohm = 8'h50;
			default: wr_ohm = 8'h00;
		endcase
	endfunction : wr_ohm

	// Driver code to ohms; code 3 reads as zero
	function automatic logic [7:0] odi_ohm(input logic [1:0] code);
		case (code)
			2'h0:    odi_ohm = 8'h22;
			2'h1:    odi_ohm = 8'h30;
			2'h2:    odi_ohm = 8'h28;
			default: odi_ohm = 8'h00;
		endcase
	endfunction : odi_ohm

	// Write column delay code to cycles
	function automatic logic [5:0] cwl_cycles(input logic [2:0] code);
		case (code)
			3'h0:    cwl_cycles = 6'h09;
			3'h1:    cwl_cycles = 6'h0a;
			3'h2:    cwl_cycles = 6'h0b;
			3'h3:    cwl_cycles = 6'h0c;
			3'h4:    cwl_cycles = 6'h0e;
			3'h5:    cwl_cycles = 6'h10;
			3'h6:    cwl_cycles = 6'h12;
			default: cwl_cycles = 6'h14;
		endcase
	endfunction : cwl_cycles

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic [13:0] mode_one;
	logic [2:0]  write_termination;
	logic [2:0]  write_cas_code;
	logic [2:0]  park_termination;
	logic        cke_q;
	logic        rd_fault_q;
	logic        wr_fault_q;
	logic [MAX_AL:0] rd_pipe;
	logic [MAX_AL:0] wr_pipe;

	wire       sel_cmd = !link.cs_n;
	wire [2:0] mr_sel  = {link.bg[0], link.ba};
	wire       is_mrs  = sel_cmd && (link.cmd == dmr_pkg::DMR_CMD_MRS);
	wire       mr0_wr  = is_mrs && (mr_sel == dmr_pkg::DMR_SEL_MR0);
	wire       mr1_wr  = is_mrs && (mr_sel == dmr_pkg::DMR_SEL_MR1);
	wire       mr2_wr  = is_mrs && (mr_sel == dmr_pkg::DMR_SEL_MR2);
	wire       mr5_wr  = is_mrs && (mr_sel == dmr_pkg::DMR_SEL_MR5);
	wire       is_rd   = sel_cmd && (link.cmd == dmr_pkg::DMR_CMD_RD);
	wire       is_wr   = sel_cmd && (link.cmd == dmr_pkg::DMR_CMD_WR);
	wire       is_ref  = sel_cmd && (link.cmd == dmr_pkg::DMR_CMD_REF);
	wire       sr_entry = is_ref && cke_q && !link.cke;
	wire       sr_exit  = self_refresh && link.cke;

	// ----------------------------------------------------------------
	// Mode register capture
	// ----------------------------------------------------------------

	// Whole first register taken in the command cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_one <= dmr_pkg::DMR_MR1_RESET;
		end else if (mr1_wr) begin
			mode_one <= link.a[13:0];
		end
	end

	// Neighbour register fields this block depends on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_termination <= dmr_pkg::DMR_FIELD3_RESET;
			write_cas_code    <= dmr_pkg::DMR_FIELD3_RESET;
			park_termination  <= dmr_pkg::DMR_FIELD3_RESET;
		end else begin
			if (mr2_wr) begin
				write_termination <= link.a[11:9];
				write_cas_code    <= link.a[5:3];
			end
			if (mr5_wr) begin
				park_termination <= link.a[8:6];
			end
		end
	end

	// Loop reset bit clears itself one cycle after it is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dll_reset_bit <= 1'b0;
		end else begin
			dll_reset_bit <= mr0_wr && link.a[8];
		end
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	wire [1:0] al_code  = mode_one[4:3];
	wire       dll_bit  = mode_one[dmr_pkg::DMR_MR1_DLL];
	wire       dll_ready = dll_active && dll_locked;
	wire [5:0] al_tap;

	assign output_disable           = mode_one[dmr_pkg::DMR_MR1_QOFF];
	assign driver_on                = !output_disable;
	assign extra_termination_strobe =
		mode_one[dmr_pkg::DMR_MR1_EXTRA_TERMINATION_STROBE] && IS_X8;
	assign nominal_termination_ohm  = nom_ohm(mode_one[10:8]);
	assign write_leveling_mode      =
		mode_one[dmr_pkg::DMR_MR1_WLEV];
	assign receiver_equalization    = {mode_one[13], mode_one[6:5]};
	assign driver_impedance_ohm     = output_disable ? 8'h00 :
		odi_ohm(mode_one[2:1]);
	assign additive_cmd_delay =
		(al_code == dmr_pkg::DMR_AL_M1) ? read_cas_delay - 6'h01 :
		(al_code == dmr_pkg::DMR_AL_M2) ? read_cas_delay - 6'h02 :
		6'h00;
	assign read_total_delay  = {1'b0, additive_cmd_delay} +
		{1'b0, read_cas_delay};
	assign write_total_delay = {1'b0, additive_cmd_delay} +
		{1'b0, cwl_cycles(write_cas_code)};

	// Loop runs when enabled and not in self-refresh
	assign dll_active = dll_bit && !self_refresh;

	// ----------------------------------------------------------------
	// Self-refresh and loop lock
	// ----------------------------------------------------------------

	// Track clock enable and self-refresh state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cke_q        <= 1'b1; // Idle level of the pin
			self_refresh <= 1'b0;
		end else begin
			cke_q <= link.cke;
			if (sr_entry) begin
				self_refresh <= 1'b1;
			end else if (sr_exit) begin
				self_refresh <= 1'b0;
			end
		end
	end

	// Relock after a loop reset or after self-refresh exit
	dmr_lock_timer #(
		.CYCLES (dmr_pkg::DMR_LOCK_CYCLES)
	) u_lock (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (dll_reset_bit || (sr_exit && dll_bit)),
		.enable  (dll_active),
		.hold_ok (link.cke),
		.busy    (),
		.locked  (dll_locked)
	);

	// ----------------------------------------------------------------
	// Additive latency hold
	// ----------------------------------------------------------------

	// Column commands shift through; tap picks the held copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_pipe <= '0;
			wr_pipe <= '0;
		end else begin
			rd_pipe <= {rd_pipe[MAX_AL-1:0], is_rd};
			wr_pipe <= {wr_pipe[MAX_AL-1:0], is_wr};
		end
	end

	assign al_tap = (additive_cmd_delay > AL_MAX_TAP) ? AL_MAX_TAP :
		additive_cmd_delay;
	assign int_read  = rd_pipe[al_tap];
	assign int_write = wr_pipe[al_tap];

	// Flag reads, and writes with write termination set, that ran without a locked loop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_fault_q <= 1'b0;
			wr_fault_q <= 1'b0;
		end else begin
			rd_fault_q <= int_read && !dll_ready;
			wr_fault_q <= int_write && !dll_ready &&
				(write_termination != 3'h0);
		end
	end

	assign read_dll_fault  = rd_fault_q;
	assign write_dll_fault = wr_fault_q;

	// ----------------------------------------------------------------
	// Termination selection
	// ----------------------------------------------------------------

	// Off when outputs disabled, write value during writes, park on low pin
	assign termination_ohm =
		output_disable ? 8'h00 :
		(int_write && (write_termination != 3'h0)) ?
			wr_ohm(write_termination) :
		!link.odt ? nom_ohm(park_termination) :
		nominal_termination_ohm;

endmodule : dmr_dram_end

// ### hdl/dmr_link_if.sv
`timescale 1ns/1ps
interface dmr_link_if;
	logic        cs_n;
	logic [3:0]  cmd;
	logic        cke;
	logic        odt;
	logic [1:0]  bg;
	logic [1:0]  ba;
	logic [17:0] a;

	modport ctrl (output cs_n, cmd, cke, odt, bg, ba, a);
	modport dev  (input cs_n, cmd, cke, odt, bg, ba, a);
endinterface : dmr_link_if

// ### hdl/dmr_lock_timer.sv
`timescale 1ns/1ps
module dmr_lock_timer #(
	parameter int CYCLES = dmr_pkg::DMR_LOCK_CYCLES
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic start,
	input  wire logic enable,
	input  wire logic hold_ok,
	// Status
	output logic      busy,
	output logic      locked
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);
	localparam logic [CW-1:0] ONE  = CW'(1);

	logic [CW-1:0] count;

	// Count the lock interval; a low hold input restarts it.
	// A start beats a low enable, so a relock launched in the
	// very cycle that leaves self-refresh is not lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count  <= '0;
			busy   <= 1'b0;
			locked <= 1'b0;
		end else if (start || (enable && busy && !hold_ok)) begin
			count  <= LOAD;
			busy   <= 1'b1;
			locked <= 1'b0;
		end else if (!enable) begin
			busy   <= 1'b0;
			locked <= 1'b0;
		end else if (busy) begin
			count  <= count - ONE;
			busy   <= (count != ONE);
			locked <= (count == ONE);
		end
	end
endmodule : dmr_lock_timer

// ### hdl/dmr_pkg.sv
package dmr_pkg;

	// ----------------------------------------------------------------
	// Command pins {act_n, ras_n, cas_n, we_n} and register select
	// ----------------------------------------------------------------
	localparam logic [3:0] DMR_CMD_NOP = 4'hf;
	localparam logic [3:0] DMR_CMD_MRS = 4'h8;
	localparam logic [3:0] DMR_CMD_REF = 4'h9;
	localparam logic [3:0] DMR_CMD_RD  = 4'hd;
	localparam logic [3:0] DMR_CMD_WR  = 4'hc;
	localparam logic [3:0] DMR_CMD_ACT = 4'h0;
	localparam logic [2:0] DMR_SEL_MR0 = 3'h0;
	localparam logic [2:0] DMR_SEL_MR1 = 3'h1;
	localparam logic [2:0] DMR_SEL_MR2 = 3'h2;
	localparam logic [2:0] DMR_SEL_MR5 = 3'h5;

	// ----------------------------------------------------------------
	// Mode image layout (bits 21:0 on bg, ba and a pins)
	// ----------------------------------------------------------------
	localparam int DMR_A_W      = 18;
	localparam int DMR_IMG_W    = 22;
	localparam int DMR_SEL_LO   = 18;
	localparam int DMR_MR1_W    = 14;
	localparam int DMR_MR1_RXEQ2 = 13;
	localparam int DMR_MR1_QOFF = 12;
	localparam int DMR_MR1_EXTRA_TERMINATION_STROBE = 11;
	localparam int DMR_MR1_NOM_HI = 10;
	localparam int DMR_MR1_NOM_LO = 8;
	localparam int DMR_MR1_WLEV = 7;
	localparam int DMR_MR1_RXEQ1 = 6;
	localparam int DMR_MR1_RXEQ0 = 5;
	localparam int DMR_MR1_AL_HI = 4;
	localparam int DMR_MR1_AL_LO = 3;
	localparam int DMR_MR1_ODI_HI = 2;
	localparam int DMR_MR1_ODI_LO = 1;
	localparam int DMR_MR1_DLL  = 0;
	localparam int DMR_MR2_WR_HI = 11;
	localparam int DMR_MR2_WR_LO = 9;
	localparam int DMR_MR2_CWL_HI = 5;
	localparam int DMR_MR2_CWL_LO = 3;
	localparam int DMR_MR5_PARK_HI = 8;
	localparam int DMR_MR5_PARK_LO = 6;
	localparam int DMR_MR0_DLL_RST = 8;

	// Sanitising masks for the controller
	localparam logic [21:0] DMR_RSV_MASK  = 22'h220000;
	localparam logic [21:0] DMR_RXEQ_MASK = 22'h002060;
	localparam logic [21:0] DMR_NOM_MASK  = 22'h000700;
	localparam logic [21:0] DMR_WRT_MASK  = 22'h000600;

	// Additive latency codes
	localparam logic [1:0] DMR_AL_OFF = 2'h0;
	localparam logic [1:0] DMR_AL_M1  = 2'h1;
	localparam logic [1:0] DMR_AL_M2  = 2'h2;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [13:0] DMR_MR1_RESET  = 14'h0000;
	localparam logic [2:0]  DMR_FIELD3_RESET = 3'h0;
	localparam int          DMR_LOCK_CYCLES = 512;
	localparam int          DMR_MAX_AL     = 32;

	// ----------------------------------------------------------------
	// Controller registers on APB
	// ----------------------------------------------------------------
	localparam logic [7:0] DMR_REG_CMD    = 8'h00;
	localparam logic [7:0] DMR_REG_DATA   = 8'h04;
	localparam logic [7:0] DMR_REG_STATUS = 8'h08;
	localparam logic [7:0] DMR_REG_CONFIG = 8'h0c;
	localparam int DMR_ST_LOCK = 0;
	localparam int DMR_ST_ERR  = 1;
	localparam int DMR_ST_DLL  = 2;
	localparam int DMR_ST_SR   = 3;
	localparam int DMR_CF_GEAR = 0;
	localparam int DMR_CF_ODT  = 1;

	typedef enum logic [2:0] {
		DMR_OP_NOP,
		DMR_OP_MRS,
		DMR_OP_ACT,
		DMR_OP_RD,
		DMR_OP_WR,
		DMR_OP_SRE,
		DMR_OP_SRX
	} dmr_op_t;

endpackage : dmr_pkg

// ### testbench/dmr_chk.sv
`timescale 1ns/1ps
module dmr_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Link pins
	input wire logic        cs_n,
	input wire logic [3:0]  cmd,
	input wire logic        cke,
	input wire logic        odt,
	input wire logic [1:0]  bg,
	input wire logic [1:0]  ba,
	input wire logic [17:0] a
);
	localparam int LK = dmr_pkg::DMR_LOCK_CYCLES;
	// Command decode
	wire logic       mrs = !cs_n && cmd == dmr_pkg::DMR_CMD_MRS;
	wire logic       rdc = !cs_n && cmd == dmr_pkg::DMR_CMD_RD;
	wire logic [2:0] sel = {bg[0], ba};
	logic            dll;
	int              lk;
	// Loop shadow and lock interval counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dll <= 1'b0;
			lk <= LK;
		end else begin
			if (mrs && sel == 3'h1)
				dll <= a[0];
			if (mrs && sel == 3'h0 && a[8] && dll)
				lk <= 0;
			else if (lk < LK)
				lk <= lk + 1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// Link checks
	// ------------------------------------------------------------
	a_rsv_zero: assert property (mrs |-> !bg[1] && !a[17])
		else $error("reserved bit high");
	a_rxeq_zero: assert property (
		mrs && sel == 3'h1 |-> {a[13], a[6:5]} == 3'h0)
		else $error("equalization not zero");
	a_nom_off: assert property (
		mrs && sel == 3'h1 && !a[0] |-> a[10:8] == 3'h0)
		else $error("nominal set with loop off");
	a_wrt_off: assert property (
		mrs && sel == 3'h2 && !dll |-> a[10:9] == 2'h0)
		else $error("write termination with loop off");
	a_odt_off: assert property (!dll && !$past(dll) |-> !odt)
		else $error("odt high with loop off");
	a_sr_entry: assert property (
		$fell(cke) |-> !cs_n && cmd == dmr_pkg::DMR_CMD_REF)
		else $error("cke fell without refresh");
	a_cke_lock: assert property (lk < LK - 4 |-> cke)
		else $error("cke low in lock interval");
	a_read_lock: assert property (rdc |-> dll && lk >= LK - 4)
		else $error("read before lock");
endmodule : dmr_chk

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, err, seen;
	logic        pready, pslverr, o_dis, o_ts, o_wl, dlla, dlr, srf, ird;
	logic        don, dlk, iwr;
	logic [7:0]  paddr, nomo, drvo, term;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  cl, alo;
	logic [6:0]  rtd, wtd;
	logic [2:0]  rxq;
	logic [15:0] lf;
	logic [21:0] img;
	int          n_fail, check_count, al, i, k;
	int          nom[8] = '{0, 60, 120, 40, 240, 48, 80, 34};
	int          driver_impedance[4] = '{34, 48, 40, 0};
	// Both ends joined by the link
	dmr_link_if link ();
	dmr_ctrl_end dmr_ctrl_end_i (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .link(link.ctrl));
	dmr_dram_end dmr_dram_end_i (.pclk, .presetn, .link(link.dev),
		.read_cas_delay(cl), .output_disable(o_dis),
		.extra_termination_strobe(o_ts), .nominal_termination_ohm(nomo),
		.write_leveling_mode(o_wl), .receiver_equalization(rxq),
		.additive_cmd_delay(alo), .driver_impedance_ohm(drvo),
		.read_total_delay(rtd), .write_total_delay(wtd), .driver_on(don),
		.termination_ohm(term), .dll_active(dlla), .dll_locked(dlk),
		.dll_reset_bit(dlr), .self_refresh(srf), .int_read(ird),
		.int_write(iwr), .read_dll_fault(), .write_dll_fault());
	dmr_chk dmr_chk_i (.pclk, .presetn, .cs_n(link.cs_n), .cmd(link.cmd),
		.cke(link.cke), .odt(link.odt), .bg(link.bg), .ba(link.ba),
		.a(link.a));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Loop reset pulse catcher
	always @(posedge pclk) if (dlr) seen <= 1'b1;
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nx
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// One APB transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic issue(input logic [2:0] op, input logic [21:0] d);
		apb(1'b1, 8'h04, {10'h0, d});
		apb(1'b1, 8'h00, {29'h0, op});
		repeat (3) @(posedge pclk);
	endtask : issue
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	// Watchdog
	initial begin
		#200000;
		n_fail++;
		test_done();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, seen} = '0;
		cl = 6'd12;
		lf = 16'd8276;
		n_fail = 0;
		check_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(drvo, 34);
		chk(dlla, 0);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1);
		apb(1'b1, 8'h0c, 32'h2);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 2);
		for (i = 0; i < 16; i++) begin
			lf = nx(lf);
			cl <= 6'd10 + lf[15:14];
			img = {5'h13, 3'h0, lf[13:11], i[2:0], lf[7:1], 1'b1};
			issue(3'h1, img);
			al = lf[4:3] == 2'h1 ? cl - 1 : lf[4:3] == 2'h2 ? cl - 2 : 0;
			chk(o_dis, lf[12]);
			chk(o_ts, lf[11]);
			chk(nomo, nom[i % 8]);
			chk(o_wl, lf[7]);
			chk(rxq, 0);
			chk(alo, al);
			chk(drvo, lf[12] ? 0 : driver_impedance[lf[2:1]]);
			chk(rtd, al + cl);
			chk(wtd, al + 9);
			chk(don, !lf[12]);
			chk(dlla, 1);
		end
		cl <= 6'd12;
		issue(3'h1, 22'h040500);
		chk(nomo, 0);
		issue(3'h1, 22'h080200);
		issue(3'h1, 22'h140100);
		issue(3'h1, 22'h040111);
		chk(term, 60);
		apb(1'b1, 8'h0c, 32'h0);
		repeat (3) @(posedge pclk);
		chk(term, 240);
		apb(1'b1, 8'h0c, 32'h3);
		issue(3'h1, 22'h040109);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[1], 1);
		chk(alo, 10);
		apb(1'b1, 8'h0c, 32'h2);
		apb(1'b1, 8'h08, 32'h2);
		issue(3'h5, 22'h0);
		chk({srf, dlla}, 2);
		issue(3'h6, 22'h0);
		chk({srf, dlla}, 1);
		issue(3'h1, 22'h000100);
		chk(seen, 1);
		issue(3'h3, 22'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[1:0], 3);
		repeat (520) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[0], 0);
		chk(dlk, 1);
		apb(1'b1, 8'h00, 32'h3);
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (!ird && k < 200);
		// Commit edge, link edge, then additive delay 10: pulse at k = 12
		chk(k, 12);
		// Write termination 120 ohm, then a WRITE held the same delay
		issue(3'h1, 22'h080200);
		apb(1'b1, 8'h00, 32'h4);
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (!iwr && k < 200);
		chk(k, 12);
		chk(term, 120);
		test_done();
	end
endmodule : testbench
